// File: hw/slpc_pkg.sv
// Shared constants and types for the short, load and power control block.
// Behaviour
// [R01] Short detection runs only while enabled.
// [R02] Short interrupt raised only when enabled.
// [R03] Short flag sticky; write 0 clears.
// [R04] Short flag reads 0 while disabled.
// [R05] Short comparator output readable, read-only.
// [R06] Comparator rising starts the delay interval.
// [R07] Delay end sets flag, clears both FETs.
// [R08] Short gone early aborts, grounds delay node.
// [R09] Delay is 100 us per nanofarad.
// [R10] Load comparator and pull-down only when enabled.
// [R11] Load interrupt on rise only when enabled.
// [R12] Load flag sticky, write 0 clears.
// [R13] Load state read-only, zero when disabled.
// [R14] Power save follows its request bit.
// [R15] Power save stops measurement and comparators; the code stops measurement and the load comparator, short detection keeps running.
// [R16] Host re-enables comparators after power save.
// [R17] Power down: pull-up, stop all, reset low.
// [R18] Wake pin low defers power down entry.
// [R19] Host turns FETs off before power down.
// [R20] Wake pin state readable; host checks it.
// [R21] Charger or wake pin low ends power down.
// [R22] Supply grounded in power down; host re-inits.
// [R23] Host rewrites FET bits after short.
// [R24] Interrupt output low while any flag set.
package slpc_pkg;
  // Device register offsets.
  localparam logic [7:0] ADDR_FET = 8'h03;
  localparam logic [7:0] ADDR_SENSE = 8'h05;
  localparam logic [7:0] ADDR_POWER = 8'h06;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  // Fet register fields.
  localparam int FET_DISCHG = 0;
  localparam int FET_CHG = 1;
  // Sense register fields.
  localparam int SNS_LOAD_STATE = 0;
  localparam int SNS_LOAD_FLAG = 1;
  localparam int SNS_LOAD_IRQ_EN = 2;
  localparam int SNS_LOAD_EN = 3;
  localparam int SNS_SHORT_CMP = 4;
  localparam int SNS_SHORT_FLAG = 5;
  localparam int SNS_SHORT_IRQ_EN = 6;
  localparam int SNS_SHORT_EN = 7;
  // Power register fields.
  localparam int PWR_SAVE = 0;
  localparam int PWR_DOWN = 4;
  localparam int PWR_WAKE = 7;
  // Short delay timing.
  localparam int unsigned SC_US_PER_NF = 100;
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned DELAY_CAP_NODE_NF_DEFAULT = 10;
  localparam int unsigned DLY_W = 24;
  // Host-side Wishbone register offsets and fields.
  localparam logic [3:0] WB_CMD = 4'h0;
  localparam logic [3:0] WB_STATUS = 4'h4;
  localparam int CMD_ADDR_LSB = 8;
  localparam int CMD_WE = 16;
  localparam int CMD_GO = 31;
  localparam int ST_BUSY = 8;
  localparam int ST_IRQ = 9;
  localparam int ST_RESET = 10;
  typedef enum logic [1:0] {PS_NORMAL, PS_SAVE, PS_DOWN} slpc_pstate_e;
  typedef enum logic {HS_IDLE, HS_REQ} slpc_hstate_e;
endpackage

// File: hw/slpc_link_if.sv
// Link between the protection device and its controller.
`timescale 1ns/100ps
interface slpc_link_if;
  logic req;
  logic we;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic ack;
  logic [7:0] rdata;
  logic irq_out_n;
  logic mcu_reset_out_n;
  modport dev (
    input req, we, addr, wdata,
    output ack, rdata, irq_out_n, mcu_reset_out_n
  );
  modport host (
    output req, we, addr, wdata,
    input ack, rdata, irq_out_n, mcu_reset_out_n
  );
endinterface

// File: hw/slpc_device.sv
// Device end: registers, short delay timer, load sensing and power states.
`timescale 1ns/100ps
module slpc_device #(
  parameter int unsigned DELAY_CAP_NODE_NF = slpc_pkg::DELAY_CAP_NODE_NF_DEFAULT
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Link to the controller
  slpc_link_if.dev link,
  // Analog comparator levels and pins
  input wire logic short_compare_in,
  input wire logic load_open_in,
  input wire logic charger_detect_in,
  input wire logic wake_in_n,
  // Analog controls
  output logic dischg_fet_drive,
  output logic chg_fet_drive,
  output logic delay_cap_charge,
  output logic load_pulldown_en,
  output logic charger_pullup_en,
  output logic mcu_supply_on,
  output logic measure_en,
  output logic short_detect_active
);
  // Delay in cycles: 100 us per nF at the clock period.
  localparam int unsigned DLY_CYC_I =
    DELAY_CAP_NODE_NF * slpc_pkg::SC_US_PER_NF * 1000 / slpc_pkg::CLK_PERIOD_NS;
  localparam logic [slpc_pkg::DLY_W-1:0] DLY_LAST =
    slpc_pkg::DLY_W'((DLY_CYC_I < 1 ? 1 : DLY_CYC_I) - 1); // R09

  logic df, cf, next_df, next_cf;
  logic short_detect_enable, short_irq_enable, short_irq_flag, load_compare_enable, load_irq_enable, load_irq_flag;
  logic next_esc, next_isc, next_rsc, next_ers, next_irs, next_rrs;
  logic power_save_request, power_down_request, next_psv, next_power_down_request;
  slpc_pkg::slpc_pstate_e pstate, next_pstate;
  logic [slpc_pkg::DLY_W-1:0] cnt, next_cnt;
  logic fired, next_fired;
  logic rs_q, next_rs_q;
  logic ack, next_ack;
  logic [7:0] rdata, next_rdata;
  logic irq_n, next_irq_n;
  logic rst_n_out, next_rst_n_out;
  logic next_cap, next_pulldown, next_pullup, next_supply, next_measure, next_sdet;
  logic sc_now, rs_now, short_evt, load_evt, wr;

  always_comb begin
    next_df = df;
    next_cf = cf;
    next_esc = short_detect_enable;
    next_isc = short_irq_enable;
    next_rsc = short_irq_flag;
    next_ers = load_compare_enable;
    next_irs = load_irq_enable;
    next_rrs = load_irq_flag;
    next_psv = power_save_request;
    next_power_down_request = power_down_request;
    next_pstate = pstate;
    next_cnt = cnt;
    next_fired = fired;
    next_rdata = rdata;
    // Comparator levels as seen by the logic; all circuits stop in power down.
    sc_now = short_compare_in & short_detect_enable & (pstate != slpc_pkg::PS_DOWN); // R01 R05
    rs_now = load_open_in & load_compare_enable & (pstate == slpc_pkg::PS_NORMAL); // R13 R15
    next_rs_q = rs_now;
    load_evt = rs_now & ~rs_q;
    short_evt = 1'b0;
    // The timer fires once per short episode, then waits for the short to go.
    if (!sc_now) begin
      next_cnt = '0; // R08
      next_fired = 1'b0; // R08
    end else if (!fired) begin
      if (cnt == DLY_LAST) begin
        short_evt = 1'b1; // R07
        next_fired = 1'b1;
      end else begin
        next_cnt = cnt + 1'b1; // R06
      end
    end
    // One-cycle acknowledge; a request still held after its ack is taken again two cycles later.
    next_ack = link.req & ~ack;
    wr = next_ack & link.we;
    if (wr) begin
      if (link.addr == slpc_pkg::ADDR_FET) begin
        next_df = link.wdata[slpc_pkg::FET_DISCHG];
        next_cf = link.wdata[slpc_pkg::FET_CHG];
      end else if (link.addr == slpc_pkg::ADDR_SENSE) begin
        next_esc = link.wdata[slpc_pkg::SNS_SHORT_EN]; // R01
        next_isc = link.wdata[slpc_pkg::SNS_SHORT_IRQ_EN];
        next_ers = link.wdata[slpc_pkg::SNS_LOAD_EN]; // R10
        next_irs = link.wdata[slpc_pkg::SNS_LOAD_IRQ_EN];
        if (!link.wdata[slpc_pkg::SNS_SHORT_FLAG]) begin
          next_rsc = 1'b0; // R03
        end
        if (!link.wdata[slpc_pkg::SNS_LOAD_FLAG]) begin
          next_rrs = 1'b0; // R12
        end
      end else if (link.addr == slpc_pkg::ADDR_POWER) begin
        next_psv = link.wdata[slpc_pkg::PWR_SAVE]; // R14
        next_power_down_request = link.wdata[slpc_pkg::PWR_DOWN]; // R17
      end
    end
    // Hardware events are applied after the write, so an event beats a write to the same bit.
    if (short_evt) begin
      next_df = 1'b0; // R07
      next_cf = 1'b0; // R07
      next_rsc = 1'b1; // R07
    end
    if (load_evt) begin
      next_rrs = 1'b1; // R11 R12
    end
    if (!next_isc) begin
      next_rsc = 1'b0; // R02 R04
    end
    if (!next_irs) begin
      next_rrs = 1'b0; // R11 R12
    end
    // Power state machine.
    case (pstate)
      slpc_pkg::PS_DOWN: begin
        if (charger_detect_in || !wake_in_n) begin
          next_pstate = slpc_pkg::PS_NORMAL; // R21
          next_power_down_request = 1'b0;
          next_psv = 1'b0;
        end
      end
      default: begin
        if (next_power_down_request && wake_in_n) begin
          next_pstate = slpc_pkg::PS_DOWN; // R17 R18
        end else if (next_psv) begin
          next_pstate = slpc_pkg::PS_SAVE; // R14
        end else begin
          next_pstate = slpc_pkg::PS_NORMAL; // R14
        end
      end
    endcase
    // The load comparator is left stopped after save; software restarts it.
    if (next_pstate != slpc_pkg::PS_NORMAL && pstate == slpc_pkg::PS_NORMAL) begin
      next_ers = 1'b0; // R15 R16
    end
    if (next_ack) begin
      if (link.addr == slpc_pkg::ADDR_FET) begin
        next_rdata = {6'h00, cf, df};
      end else if (link.addr == slpc_pkg::ADDR_SENSE) begin
        next_rdata = {short_detect_enable, short_irq_enable, short_irq_flag, sc_now, load_compare_enable, load_irq_enable, load_irq_flag, rs_now}; // R05 R13
      end else if (link.addr == slpc_pkg::ADDR_POWER) begin
        next_rdata = {~wake_in_n, 2'b00, power_down_request, 3'b000, power_save_request}; // R20
      end else begin
        next_rdata = slpc_pkg::RESET_BYTE;
      end
    end
    next_irq_n = ~(next_rsc | next_rrs); // R24
    next_rst_n_out = (next_pstate != slpc_pkg::PS_DOWN); // R17
    next_supply = (next_pstate != slpc_pkg::PS_DOWN); // R22
    next_pullup = (next_pstate == slpc_pkg::PS_DOWN); // R17
    next_measure = (next_pstate == slpc_pkg::PS_NORMAL); // R15
    next_pulldown = next_ers & (next_pstate == slpc_pkg::PS_NORMAL); // R10
    next_sdet = next_esc & (next_pstate != slpc_pkg::PS_DOWN); // R01 R15
    next_cap = sc_now & ~next_fired; // R06 R08
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      df <= 1'b0;
      cf <= 1'b0;
      short_detect_enable <= 1'b0;
      short_irq_enable <= 1'b0;
      short_irq_flag <= 1'b0;
      load_compare_enable <= 1'b0;
      load_irq_enable <= 1'b0;
      load_irq_flag <= 1'b0;
      power_save_request <= 1'b0;
      power_down_request <= 1'b0;
      pstate <= slpc_pkg::PS_NORMAL;
      cnt <= '0;
      fired <= 1'b0;
      rs_q <= 1'b0;
      ack <= 1'b0;
      rdata <= slpc_pkg::RESET_BYTE;
      irq_n <= 1'b1;
      rst_n_out <= 1'b1;
      delay_cap_charge <= 1'b0;
      load_pulldown_en <= 1'b0;
      charger_pullup_en <= 1'b0;
      mcu_supply_on <= 1'b1;
      measure_en <= 1'b1;
      short_detect_active <= 1'b0;
    end else begin
      df <= next_df;
      cf <= next_cf;
      short_detect_enable <= next_esc;
      short_irq_enable <= next_isc;
      short_irq_flag <= next_rsc;
      load_compare_enable <= next_ers;
      load_irq_enable <= next_irs;
      load_irq_flag <= next_rrs;
      power_save_request <= next_psv;
      power_down_request <= next_power_down_request;
      pstate <= next_pstate;
      cnt <= next_cnt;
      fired <= next_fired;
      rs_q <= next_rs_q;
      ack <= next_ack;
      rdata <= next_rdata;
      irq_n <= next_irq_n;
      rst_n_out <= next_rst_n_out;
      delay_cap_charge <= next_cap;
      load_pulldown_en <= next_pulldown;
      charger_pullup_en <= next_pullup;
      mcu_supply_on <= next_supply;
      measure_en <= next_measure;
      short_detect_active <= next_sdet;
    end
  end

  assign dischg_fet_drive = df;
  assign chg_fet_drive = cf;
  assign link.ack = ack;
  assign link.rdata = rdata;
  assign link.irq_out_n = irq_n;
  assign link.mcu_reset_out_n = rst_n_out;
endmodule

// File: hw/slpc_host.sv
// Controller end: Wishbone command registers driving device register accesses.
`timescale 1ns/100ps
module slpc_host (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [3:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Link to the device
  slpc_link_if.host link
);
  slpc_pkg::slpc_hstate_e hstate, next_hstate;
  logic req, next_req;
  logic we, next_we;
  logic [7:0] addr, next_addr;
  logic [7:0] wdata, next_wdata;
  logic [7:0] last_rd, next_last_rd;
  logic [31:0] next_dat_o;
  logic next_ack_o, take;

  always_comb begin
    next_hstate = hstate;
    next_req = req;
    next_we = we;
    next_addr = addr;
    next_wdata = wdata;
    next_last_rd = last_rd;
    next_dat_o = dat_o;
    take = cyc_i & stb_i & ~ack_o;
    next_ack_o = take;
    case (hstate)
      slpc_pkg::HS_IDLE: begin
        // A command written while busy is dropped; software polls busy first.
        if (take && we_i && adr_i == slpc_pkg::WB_CMD && sel_i[3] && dat_i[slpc_pkg::CMD_GO]) begin
          next_wdata = dat_i[7:0];
          next_addr = dat_i[slpc_pkg::CMD_ADDR_LSB +: 8];
          next_we = dat_i[slpc_pkg::CMD_WE];
          next_req = 1'b1;
          next_hstate = slpc_pkg::HS_REQ;
        end
      end
      default: begin
        if (link.ack) begin
          next_req = 1'b0;
          next_last_rd = link.rdata;
          next_hstate = slpc_pkg::HS_IDLE;
        end
      end
    endcase
    if (take && !we_i) begin
      if (adr_i == slpc_pkg::WB_CMD) begin
        next_dat_o = {15'h0000, we, addr, wdata};
      end else if (adr_i == slpc_pkg::WB_STATUS) begin
        next_dat_o = {21'h000000, ~link.mcu_reset_out_n, ~link.irq_out_n,
                      hstate == slpc_pkg::HS_REQ, last_rd};
      end else begin
        next_dat_o = 32'h00000000;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      hstate <= slpc_pkg::HS_IDLE;
      req <= 1'b0;
      we <= 1'b0;
      addr <= 8'h00;
      wdata <= 8'h00;
      last_rd <= 8'h00;
      dat_o <= 32'h00000000;
      ack_o <= 1'b0;
    end else begin
      hstate <= next_hstate;
      req <= next_req;
      we <= next_we;
      addr <= next_addr;
      wdata <= next_wdata;
      last_rd <= next_last_rd;
      dat_o <= next_dat_o;
      ack_o <= next_ack_o;
    end
  end

  assign link.req = req;
  assign link.we = we;
  assign link.addr = addr;
  assign link.wdata = wdata;
endmodule

// File: bench/slpc_chk.sv
// Checker for the link that joins the device end and the controller end.
`timescale 1ns/100ps
module slpc_chk (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Link signals
  input wire logic req,
  input wire logic we,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic ack,
  input wire logic [7:0] rdata,
  input wire logic irq_out_n,
  input wire logic mcu_reset_out_n
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  wire logic take;
  wire logic take5;
  assign take = req && !ack && !we;
  assign take5 = take && addr == slpc_pkg::ADDR_SENSE;
  property p_answer; req && !ack |=> ack; endproperty
  a_answer: assert property (p_answer) else $error("link ack missing");
  property p_pulse; ack |=> !ack; endproperty
  a_pulse: assert property (p_pulse) else $error("link ack longer than one cycle");
  property p_hold; !ack |-> $stable(rdata); endproperty
  a_hold: assert property (p_hold) else $error("read byte changed without ack");
  property p_unmapped;
    take && !(addr inside {8'h03, 8'h05, 8'h06}) |=> rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_pwr; take && addr == slpc_pkg::ADDR_POWER |=> (rdata & 8'h6E) == 8'h00; endproperty
  a_pwr: assert property (p_pwr) else $error("power byte unused bits set");
  property p_sflag; take5 ##1 !rdata[6] |-> !rdata[5]; endproperty
  a_sflag: assert property (p_sflag) else $error("short flag set while disabled");
  property p_lflag; take5 ##1 !rdata[2] |-> !rdata[1]; endproperty
  a_lflag: assert property (p_lflag) else $error("load flag set while disabled");
  property p_lstate; take5 ##1 !rdata[3] |-> !rdata[0]; endproperty
  a_lstate: assert property (p_lstate) else $error("load state set while stopped");
  property p_irq; take5 ##1 (rdata[5] || rdata[1]) |-> ##[0:2] !irq_out_n; endproperty
  a_irq: assert property (p_irq) else $error("flag set but irq high");
endmodule

// File: bench/short_load_power_control_tb.sv
// Testbench joining the device end and the controller end of the block.
`timescale 1ns/100ps
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin failures++; \
  $display("wrong value %s exp %h got %h", n, e, g); end end
module short_load_power_control_tb;
  logic mclk = 0, rst = 1, cyc = 0, stb = 0, wen = 0;
  logic [3:0] adr = 4'h0;
  logic [31:0] dat = 32'h0, dat_o;
  logic ack_o, dfet, cfet, cap, pd, pu, sup, meas, sact;
  logic short_in = 0, lopen = 0, chg_in = 0, wake_n = 1;
  logic [7:0] got, e;
  logic [7:0] exp_q[$];
  int failures = 0, n_compared = 0;
  event got_ev;
  wire logic [9:0] mon;
  slpc_link_if link ();
  assign mon = {link.mcu_reset_out_n, link.irq_out_n, dfet, cfet, cap, pd, pu, sup, meas, sact};
  slpc_device #(.DELAY_CAP_NODE_NF(1)) slpc_device_inst (.mclk(mclk), .rst(rst), .link(link),
    .short_compare_in(short_in), .load_open_in(lopen), .charger_detect_in(chg_in),
    .wake_in_n(wake_n), .dischg_fet_drive(dfet), .chg_fet_drive(cfet),
    .delay_cap_charge(cap), .load_pulldown_en(pd), .charger_pullup_en(pu),
    .mcu_supply_on(sup), .measure_en(meas), .short_detect_active(sact));
  slpc_host slpc_host_inst (.mclk(mclk), .rst(rst), .cyc_i(cyc), .stb_i(stb), .we_i(wen),
    .adr_i(adr), .sel_i(4'hF), .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o), .link(link));
  slpc_chk slpc_chk_inst (.mclk(mclk), .rst(rst), .req(link.req), .we(link.we),
    .addr(link.addr), .wdata(link.wdata), .ack(link.ack), .rdata(link.rdata),
    .irq_out_n(link.irq_out_n), .mcu_reset_out_n(link.mcu_reset_out_n));
  always #50 mclk = ~mclk;
  task automatic finish_test();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Classic single cycle; the request stands until ack is sampled high.
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int i;
    cyc <= 1'b1;
    stb <= 1'b1;
    wen <= w;
    adr <= a;
    dat <= d;
    for (i = 0; i < 40 && ack_o !== 1'b1; i++) @(posedge mclk);
    if (i == 40) begin
      failures++;
      finish_test();
    end
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic dev(input logic w, input logic [7:0] a, d, output logic [7:0] q);
    logic [31:0] s;
    int j;
    wb(1'b1, slpc_pkg::WB_CMD, {1'b1, 14'h0, w, a, d}, s);
    s = 32'h100;
    for (j = 0; j < 20 && s[slpc_pkg::ST_BUSY] !== 1'b0; j++)
      wb(1'b0, slpc_pkg::WB_STATUS, 32'h0, s);
    if (j == 20) begin
      failures++;
      finish_test();
    end
    q = s[7:0];
  endtask
  task automatic wr(input logic [7:0] a, d);
    logic [7:0] q;
    dev(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, x);
    logic [7:0] q;
    exp_q.push_back(x);
    dev(1'b0, a, 8'h00, q);
    got = q;
    -> got_ev;
  endtask
  task automatic wait_on(input int b, input logic v, input int lim, output int n);
    for (n = 0; n < lim && mon[b] !== v; n++) @(posedge mclk);
    if (n == lim) begin
      failures++;
      finish_test();
    end
  endtask
  always @(got_ev) begin
    e = exp_q.pop_front();
    `CHK("read byte", e, got)
  end
  initial begin
    int n;
    logic [7:0] r;
    logic [31:0] w32;
    void'($urandom(32'hcd1b3fea));
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    `CHK("reset outputs", 10'b1100000110, mon)
    rd(8'h05, 8'h00);
    rd(8'h06, 8'h00);
    r = $urandom;
    wr(8'h0F, r);
    rd(8'h0F, 8'h00);
    wr(8'h03, {r[7:2], 2'b11});
    rd(8'h03, 8'h03);
    // The load interrupt is enabled only once its comparator has run for over 1 ms.
    wr(8'h05, 8'h88);
    repeat (10001) @(posedge mclk);
    wr(8'h05, 8'hFF);
    rd(8'h05, 8'hCC);
    `CHK("enabled", 10'b1111010111, mon)
    lopen <= 1'b1;
    wait_on(8, 1'b0, 20, n);
    rd(8'h05, 8'hCF);
    wr(8'h05, 8'hCC);
    rd(8'h05, 8'hCD);
    `CHK("irq released", 1'b1, mon[8])
    lopen <= 1'b0;
    short_in <= 1'b1;
    repeat (500) @(posedge mclk);
    `CHK("charging", 1'b1, mon[5])
    short_in <= 1'b0;
    repeat (3) @(posedge mclk);
    `CHK("aborted", 10'b1111010111, mon)
    short_in <= 1'b1;
    wait_on(7, 1'b0, 1100, n);
    `CHK("short delay", 1'b1, n >= 1000 && n <= 1004)
    wait_on(8, 1'b0, 5, n);
    `CHK("fets off", 2'b00, mon[7:6])
    rd(8'h05, 8'hFC);
    short_in <= 1'b0;
    wr(8'h05, 8'hAC);
    rd(8'h05, 8'h8C);
    `CHK("fets stay off", 2'b00, mon[7:6])
    wr(8'h05, 8'hCC);
    wr(8'h06, 8'h01);
    rd(8'h05, 8'hC4);
    `CHK("power save", 10'b1100000101, mon)
    wr(8'h06, 8'h00);
    wr(8'h05, 8'hCC);
    `CHK("normal", 10'b1100010111, mon)
    wake_n <= 1'b0;
    rd(8'h06, 8'h80);
    wr(8'h06, 8'h10);
    repeat (20) @(posedge mclk);
    `CHK("deferred", 1'b1, mon[9])
    // Both wake sources end power down: charger first, then the wake pin.
    for (int i = 0; i < 2; i++) begin
      if (i == 1) wr(8'h06, 8'h10);
      wake_n <= 1'b1;
      wait_on(9, 1'b0, 20, n);
      `CHK("power down", 5'b01000, mon[4:0])
      wb(1'b0, slpc_pkg::WB_STATUS, 32'h0, w32);
      `CHK("status flags", 2'b10, w32[slpc_pkg::ST_RESET -: 2])
      wb(1'b0, slpc_pkg::WB_CMD, 32'h0, w32);
      `CHK("last command", 32'h00010610, w32)
      if (i == 0) chg_in <= 1'b1;
      else wake_n <= 1'b0;
      wait_on(9, 1'b1, 20, n);
      chg_in <= 1'b0;
      wake_n <= 1'b1;
      rd(8'h06, 8'h00);
      wr(8'h05, 8'hCC);
      `CHK("re-init", 1'b1, mon[4])
    end
    finish_test();
  end
  initial begin
    #(100 * 100000);
    failures++;
    finish_test();
  end
endmodule
